// file: hdl/pfic_cfg.svh
// Register offsets, field positions and reset values of the irq collector
`ifndef PFIC_CFG_SVH
`define PFIC_CFG_SVH
`define PFIC_BASE_ADDR 16'h1100
`define PFIC_PEND_OFF 16'h0000
`define PFIC_EN_OFF 16'h0010
`define PFIC_TYPE_OFF 16'h0020
`define PFIC_POL_OFF 16'h0030
`define PFIC_VECT_OFF 16'h0040
`define PFIC_URG_OFF 16'h0044
`define PFIC_PFAIL_OFF 16'h0048
`define PFIC_WAKE_OFF 16'h0384
`define PFIC_SPAN 16'h0400
`define PFIC_WAKE_IDX 8'he1
`define PFIC_WAKE_RST 8'h01
`define PFIC_WAKE_PDC 0
`define PFIC_WAKE_SKIP 1
`define PFIC_PF_ONCE 0
`define PFIC_PF_LOCK 1
`define PFIC_NCH 32
`define PFIC_NREG 8
`define PFIC_RESP_OKAY 2'h0
`define PFIC_RESP_SLVERR 2'h2
`endif

// file: hdl/pfic_irq_collector.sv
// Power-fail trap and maskable irq collector with AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "pfic_cfg.svh"
module pfic_irq_collector (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] irq_src,
  input wire logic [31:0] irq_external,
  input wire logic power_fail_in_n,
  input wire logic [1:0] core_mode,
  output logic urgent_irq_out_n,
  output logic maskable_irq_out_n,
  output logic wake_req,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // Core modes: 0 run, 1 idle, 2 doze, 3 sleep
  logic [31:0] pend_reg, pend_next, src_dly_reg, src_dly_next;
  logic [31:0] en_word, type_word, pol_word, mem_rd;
  logic pf_dly_reg, pf_dly_next, urg_reg, urg_next;
  logic [1:0] arm_reg, arm_next;
  logic [7:0] wake_reg, wake_next;
  logic [4:0] vect_reg, vect_next;
  logic maskable_n_reg, maskable_n_next, wake_req_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [15:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic rd_mem_reg, rd_mem_next;
  pfic_pkg::pfic_bus_e st_reg, st_next;
  logic do_wr, do_rd, wr_ok, rd_ok;
  logic [15:0] wr_off, rd_off;
  logic ar_got_reg, ar_got_next;
  logic [15:0] ar_reg, ar_next;
  logic [1:0] mem_idx;
  logic [31:0] clr_mask, edge_hit, active_lvl, wake_ready;

  // Byte offset of a bus address from the block base
  function automatic logic [15:0] blk_off(input logic [15:0] a);
    blk_off = a - `PFIC_BASE_ADDR;
  endfunction

  // Offset within the block; out of range gives an error answer
  function automatic logic in_block(input logic [15:0] a);
    in_block = blk_off(a) < `PFIC_SPAN;
  endfunction

  // Enable, type and polarity words live in the small memory
  function automatic logic is_mem(input logic [15:0] off);
    is_mem = off[15:6] == 10'h0 && off[5:4] != 2'h0;
  endfunction

  // Highest numbered set bit, channel 31 wins
  function automatic logic [4:0] top_bit(input logic [31:0] v);
    top_bit = 5'h0;
    for (int i = 1; i < `PFIC_NCH; i++) begin
      if (v[i]) top_bit = 5'(i);
    end
  endfunction

  pfic_regmem u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(do_wr && wr_ok && is_mem(wr_off)),
    .wr_idx(mem_idx),
    .wr_data(wd_reg),
    .wr_strb(ws_reg),
    .rd_idx(rd_off[5:4] - 2'h1),
    .rd_data(mem_rd),
    .en_word(en_word),
    .type_word(type_word),
    .pol_word(pol_word)
  );

  assign mem_idx = wr_off[5:4] - 2'h1;
  assign wr_off = blk_off(aw_reg);
  assign rd_off = blk_off(ar_reg);
  assign do_wr = st_reg == pfic_pkg::PFIC_IDLE && aw_got_reg && w_got_reg;
  assign do_rd = st_reg == pfic_pkg::PFIC_IDLE && !do_wr && ar_got_reg;
  assign wr_ok = in_block(aw_reg) && aw_reg[1:0] == 2'h0;
  assign rd_ok = in_block(ar_reg) && ar_reg[1:0] == 2'h0;

  // Channel inputs: active level, selected edges and write-one clears
  always_comb begin
    active_lvl = irq_src ~^ pol_word;
    // Polarity 1 selects rising or high, 0 falling or low
    edge_hit = active_lvl & ~(src_dly_reg ~^ pol_word);
    clr_mask = 32'h0;
    if (do_wr && wr_ok && wr_off == `PFIC_PEND_OFF) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_reg[b]) clr_mask[b*8 +: 8] = wd_reg[b*8 +: 8];
      end
    end
    clr_mask = clr_mask & type_word;
    src_dly_next = irq_src;
    for (int i = 0; i < `PFIC_NCH; i++) begin
      if (i == 0) begin
        pend_next[i] = 1'b0;
      end else if (!type_word[i]) begin
        pend_next[i] = active_lvl[i];
      end else begin
        // Set wins over a simultaneous clear
        pend_next[i] = edge_hit[i] | (pend_reg[i] & ~clr_mask[i]);
      end
    end
    // Pending kept regardless of enable; gated here and in the wake-up logic
    maskable_n_next = ~|(pend_reg & en_word);
    vect_next = top_bit(pend_reg & en_word);
  end

  // Wake-up: external any low-power mode, internal only idle
  always_comb begin
    wake_ready = pend_reg & en_word;
    if (wake_reg[`PFIC_WAKE_SKIP]) wake_ready = wake_ready & active_lvl;
    wake_req_next = 1'b0;
    if (core_mode == 2'h1) begin
      wake_req_next = |wake_ready;
    end else if (core_mode != 2'h0) begin
      wake_req_next = |(wake_ready & irq_external);
    end
  end

  // Power-fail trap with single-shot and locked arming
  always_comb begin
    pf_dly_next = power_fail_in_n;
    arm_next = arm_reg;
    urg_next = urg_reg;
    wake_next = wake_reg;
    if (urg_reg && !arm_reg[`PFIC_PF_LOCK]) begin
      arm_next[`PFIC_PF_ONCE] = 1'b0;
    end
    if (do_wr && wr_ok && ws_reg[0]) begin
      if (wr_off == `PFIC_PFAIL_OFF) arm_next = wd_reg[1:0];
      if (wr_off == `PFIC_URG_OFF && wd_reg[0]) urg_next = 1'b0;
      if (wr_off == `PFIC_WAKE_OFF) wake_next = {5'h0, wd_reg[2:0]};
    end
    // A trap in the same cycle as a software clear wins
    if (|arm_reg && pf_dly_reg && !power_fail_in_n) begin
      urg_next = 1'b1;
    end
  end

  // AXI4-Lite slave: both address and data latched, then one answer
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    aw_next = aw_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    st_next = st_reg;
    bresp_next = bresp;
    rresp_next = rresp;
    rdata_next = rdata;
    rd_mem_next = 1'b0;
    ar_got_next = ar_got_reg;
    ar_next = ar_reg;
    if (arvalid && arready) begin
      ar_got_next = 1'b1;
      ar_next = araddr;
    end
    if (awvalid && awready) begin
      aw_got_next = 1'b1;
      aw_next = awaddr;
    end
    if (wvalid && wready) begin
      w_got_next = 1'b1;
      wd_next = wdata;
      ws_next = wstrb;
    end
    case (st_reg)
      pfic_pkg::PFIC_IDLE: begin
        if (do_wr) begin
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          bresp_next = wr_ok ? `PFIC_RESP_OKAY : `PFIC_RESP_SLVERR;
          st_next = pfic_pkg::PFIC_WRSP;
        end else if (do_rd) begin
          rresp_next = rd_ok ? `PFIC_RESP_OKAY : `PFIC_RESP_SLVERR;
          ar_got_next = 1'b0;
          rdata_next = 32'h0;
          rd_mem_next = rd_ok && is_mem(rd_off);
          if (rd_ok) begin
            case (rd_off)
              `PFIC_PEND_OFF: rdata_next = pend_reg;
              `PFIC_VECT_OFF: rdata_next = {27'h0, vect_reg};
              `PFIC_URG_OFF: rdata_next = {31'h0, urg_reg};
              `PFIC_PFAIL_OFF: rdata_next = {30'h0, arm_reg};
              `PFIC_WAKE_OFF: rdata_next = {24'h0, wake_reg};
              default: rdata_next = 32'h0;
            endcase
          end
          st_next = pfic_pkg::PFIC_RRSP;
        end
      end
      pfic_pkg::PFIC_WRSP: begin
        if (bready) st_next = pfic_pkg::PFIC_IDLE;
      end
      pfic_pkg::PFIC_RRSP: begin
        if (rd_mem_reg) rdata_next = mem_rd;
        if (rready && !rd_mem_reg) st_next = pfic_pkg::PFIC_IDLE;
      end
      default: st_next = pfic_pkg::PFIC_IDLE;
    endcase
  end

  // Register stage for all state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= 32'h0;
      src_dly_reg <= 32'h0;
      pf_dly_reg <= 1'b1;
      urg_reg <= 1'b0;
      arm_reg <= 2'h0;
      wake_reg <= `PFIC_WAKE_RST;
      vect_reg <= 5'h0;
      maskable_n_reg <= 1'b1;
      wake_req <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_reg <= 16'h0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      st_reg <= pfic_pkg::PFIC_IDLE;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h0;
      rd_mem_reg <= 1'b0;
      ar_got_reg <= 1'b0;
      ar_reg <= 16'h0;
      urgent_irq_out_n <= 1'b1;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      src_dly_reg <= src_dly_next;
      pf_dly_reg <= pf_dly_next;
      urg_reg <= urg_next;
      arm_reg <= arm_next;
      wake_reg <= wake_next;
      vect_reg <= vect_next;
      maskable_n_reg <= maskable_n_next;
      wake_req <= wake_req_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      st_reg <= st_next;
      bresp <= bresp_next;
      rresp <= rresp_next;
      rdata <= rdata_next;
      rd_mem_reg <= rd_mem_next;
      ar_got_reg <= ar_got_next;
      ar_reg <= ar_next;
      urgent_irq_out_n <= !urg_next;
      awready <= !aw_got_next;
      wready <= !w_got_next;
      arready <= !ar_got_next;
      bvalid <= st_next == pfic_pkg::PFIC_WRSP;
      rvalid <= st_next == pfic_pkg::PFIC_RRSP && !rd_mem_next;
    end
  end

  // Maskable request straight from its flip-flop
  assign maskable_irq_out_n = maskable_n_reg;

  a_trap_edge: assert property (@(posedge clk) disable iff (!reset_n)
    |arm_reg && $fell(power_fail_in_n) |=> ##1 !urgent_irq_out_n)
    else $error("power-fail edge not trapped");
  a_once_clear: assert property (@(posedge clk) disable iff (!reset_n)
    urg_reg && arm_reg == 2'b01 && !(do_wr && wr_off == `PFIC_PFAIL_OFF)
    |=> !arm_reg[0])
    else $error("single-shot arm not cleared");
  a_lock_keep: assert property (@(posedge clk) disable iff (!reset_n)
    urg_reg && arm_reg[1] && !do_wr |=> arm_reg[1])
    else $error("locked arm lost");
  a_mask_out: assert property (@(posedge clk) disable iff (!reset_n)
    |(pend_reg & en_word) |=> !maskable_irq_out_n)
    else $error("maskable request missing");
  a_masked_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (pend_reg & en_word) == 32'h0 |=> maskable_irq_out_n)
    else $error("maskable request without cause");
  a_level_follow: assert property (@(posedge clk) disable iff (!reset_n)
    !type_word[5] ##1 !type_word[5] |-> pend_reg[5] == $past(active_lvl[5]))
    else $error("level pending not following source");
  a_edge_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    type_word[3] && edge_hit[3] |=> pend_reg[3])
    else $error("edge event lost");
  a_vect_top: assert property (@(posedge clk) disable iff (!reset_n)
    pend_reg[31] && en_word[31] |=> vect_reg == 5'h1f)
    else $error("vector not highest channel");
endmodule // pfic_irq_collector

// file: hdl/pfic_pkg.sv
// Types shared by the irq collector design files
package pfic_pkg;
  typedef enum logic [2:0] {
    PFIC_IDLE = 3'b001,
    PFIC_WRSP = 3'b010,
    PFIC_RRSP = 3'b100
  } pfic_bus_e;
  typedef logic [31:0] pfic_word_t;
endpackage

// file: hdl/pfic_regmem.sv
// Small register memory for enable, type and polarity words
`timescale 1ns/1ps
module pfic_regmem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic [1:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [31:0] en_word,
  output logic [31:0] type_word,
  output logic [31:0] pol_word
);
  logic [31:0] mem_reg [3];
  logic [31:0] mem_next [3];
  logic [31:0] rd_data_next;

  // Byte-lane merge of a write and the registered read port
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en && wr_idx != 2'h3) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          mem_next[wr_idx][b*8 +: 8] = wr_data[b*8 +: 8];
        end
      end
    end
    rd_data_next = (rd_idx == 2'h3) ? 32'h0 : mem_reg[rd_idx];
  end

  // Register stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        mem_reg[i] <= 32'h0;
      end
      rd_data <= 32'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rd_data <= rd_data_next;
    end
  end

  assign en_word = {mem_reg[0][31:1], 1'b0};
  assign type_word = {mem_reg[1][31:1], 1'b0};
  assign pol_word = {mem_reg[2][31:1], 1'b0};
endmodule // pfic_regmem

// file: tb/pfic_core_model.sv
// Core side model of the two request inputs
`timescale 1ns/1ps
module pfic_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic urgent_irq_out_n,
  input wire logic maskable_irq_out_n,
  output logic urg_taken,
  output logic msk_taken
);
  // Both inputs are sensed as level-low, never as edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      urg_taken <= 1'b0;
      msk_taken <= 1'b0;
    end else begin
      urg_taken <= !urgent_irq_out_n;
      msk_taken <= !maskable_irq_out_n;
    end
  end
endmodule // pfic_core_model

// file: tb/testbench.sv
// Self-checking bench for the irq collector
`timescale 1ns/1ps
`include "pfic_cfg.svh"
module testbench;
  localparam logic [15:0] wake_adr = 16'(`PFIC_WAKE_IDX) << 2;
  logic clk, reset_n, power_fail_in_n, wake_req, urg_taken, msk_taken;
  logic urgent_irq_out_n, maskable_irq_out_n;
  logic [31:0] irq_src, irq_external, wdata, rdata, rv;
  logic [1:0] core_mode, bresp, rresp, rs;
  logic [15:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail, n_checks;
  pfic_irq_collector i_pfic_irq_collector (.clk, .reset_n, .irq_src,
    .irq_external, .power_fail_in_n, .core_mode, .urgent_irq_out_n,
    .maskable_irq_out_n, .wake_req, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  pfic_core_model i_pfic_core_model (.clk, .reset_n, .urgent_irq_out_n,
    .maskable_irq_out_n, .urg_taken, .msk_taken);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Word compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pin compare
  task automatic chb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus write; each channel released at the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= `PFIC_BASE_ADDR + a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // Bus read; data lands in rv, response in rs, at the rvalid edge
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    araddr <= `PFIC_BASE_ADDR + a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
  // Test sequence
  initial begin
    int i;
    reset_n = 1'b0;
    power_fail_in_n = 1'b1;
    irq_src = '0;
    irq_external = '0;
    core_mode = 2'd0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    wt(1);
    chb("urgent idle", 1'b1, urgent_irq_out_n);
    chb("maskable idle", 1'b1, maskable_irq_out_n);
    rd(wake_adr);
    chk("wake reg reset", 32'(`PFIC_WAKE_RST), rv);
    rd(16'h0f00);
    chk("far resp", 32'(`PFIC_RESP_SLVERR), 32'(rs));
    chk("far data", 32'h0, rv);
    // Active high everywhere except channel 3, which takes falling edges
    wr(`PFIC_POL_OFF, 32'hffff_fff7);
    wr(`PFIC_TYPE_OFF, 32'h8000_0008);
    // Drop edge bits left over from the level-low reset settings
    wr(`PFIC_PEND_OFF, 32'hffff_ffff);
    wr(`PFIC_EN_OFF, 32'h0000_0020);
    irq_src <= 32'h20;
    wt(4);
    rd(`PFIC_PEND_OFF);
    chk("level pending", 32'h20, rv);
    chk("base resp", 32'(`PFIC_RESP_OKAY), 32'(rs));
    chb("core maskable", 1'b1, msk_taken);
    wr(`PFIC_PEND_OFF, 32'h20);
    rd(`PFIC_PEND_OFF);
    chk("level w1", 32'h20, rv);
    irq_src <= 32'h8000_0020;
    wt(1);
    irq_src <= 32'h20;
    wt(4);
    rd(`PFIC_PEND_OFF);
    chk("masked edge", 32'h8000_0020, rv);
    rd(`PFIC_VECT_OFF);
    chk("vector masked", 32'd5, rv);
    wr(`PFIC_EN_OFF, 32'h8000_0020);
    wt(3);
    rd(`PFIC_VECT_OFF);
    chk("vector top", 32'd31, rv);
    wr(`PFIC_PEND_OFF, 32'h0);
    rd(`PFIC_PEND_OFF);
    chk("write zero", 32'h8000_0020, rv);
    wr(`PFIC_PEND_OFF, 32'h8000_0000);
    rd(`PFIC_PEND_OFF);
    chk("edge clear", 32'h20, rv);
    irq_src <= 32'h0;
    wt(4);
    rd(`PFIC_PEND_OFF);
    chk("level drop", 32'h0, rv);
    chb("maskable off", 1'b1, maskable_irq_out_n);
    rd(`PFIC_VECT_OFF);
    chk("vector none", 32'd0, rv);
    irq_src <= 32'h8;
    wt(4);
    rd(`PFIC_PEND_OFF);
    chk("rise ignored", 32'h0, rv);
    irq_src <= 32'h0;
    wt(4);
    rd(`PFIC_PEND_OFF);
    chk("fall caught", 32'h8, rv);
    chb("ch3 masked", 1'b1, maskable_irq_out_n);
    wr(`PFIC_PFAIL_OFF, 32'h1);
    power_fail_in_n <= 1'b0;
    wt(4);
    chb("urgent once", 1'b1, urg_taken);
    rd(`PFIC_PFAIL_OFF);
    chk("once arm", 32'h0, rv);
    power_fail_in_n <= 1'b1;
    wr(`PFIC_URG_OFF, 32'h1);
    wt(2);
    chb("urgent clear", 1'b1, urgent_irq_out_n);
    wr(`PFIC_PFAIL_OFF, 32'h3);
    // Two falls in a row, both trapped while locked
    for (i = 0; i < 2; i++) begin
      power_fail_in_n <= 1'b0;
      wt(4);
      chb("urgent locked", 1'b1, urg_taken);
      rd(`PFIC_PFAIL_OFF);
      chk("locked arm", 32'h2, rv & 32'h2);
      power_fail_in_n <= 1'b1;
      wr(`PFIC_URG_OFF, 32'h1);
    end
    wr(`PFIC_EN_OFF, 32'h20);
    wr(wake_adr, 32'h1);
    irq_src <= 32'h20;
    core_mode <= 2'h3;
    wt(4);
    chb("internal sleep", 1'b0, wake_req);
    irq_external <= 32'h20;
    wt(4);
    chb("external sleep", 1'b1, wake_req);
    irq_external <= 32'h0;
    core_mode <= 2'd1;
    wt(4);
    chb("internal idle", 1'b1, wake_req);
    // Channel 3 stays pending after its source is withdrawn
    irq_src <= 32'h8;
    wr(`PFIC_EN_OFF, 32'h8);
    wt(2);
    chb("stale wake", 1'b1, wake_req);
    wr(wake_adr, 32'h3);
    wt(2);
    chb("stale skipped", 1'b0, wake_req);
    rd(wake_adr);
    chk("wake reg", 32'h3, rv);
    summarize;
  end
endmodule // testbench
